/* hw/tmz_consts.vh */
`ifndef TMZ_CONSTS_VH
`define TMZ_CONSTS_VH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------
`define TMZ_IDX_COUNT_LOW    14'h059c
`define TMZ_IDX_PERIOD_HIGH  14'h059d
`define TMZ_IDX_CTRL0        14'h059e
`define TMZ_IDX_CTRL1        14'h059f
`define TMZ_IDX_IRQ_CTRL     14'h05a0

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define TMZ_CTRL0_EN_BIT     7
`define TMZ_CTRL0_OUT_BIT    5
`define TMZ_CTRL0_WIDE_BIT   4
`define TMZ_CTRL0_POST_MSB   3
`define TMZ_CTRL0_POST_LSB   0
`define TMZ_CTRL1_CS_MSB     7
`define TMZ_CTRL1_CS_LSB     5
`define TMZ_CTRL1_ASYNC_BIT  4
`define TMZ_CTRL1_PRE_MSB    3
`define TMZ_CTRL1_PRE_LSB    0
`define TMZ_IRQ_FLAG_BIT     0
`define TMZ_IRQ_EN_BIT       1

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define TMZ_RST_BYTE         8'h00
`define TMZ_RST_CS           3'h0
`define TMZ_RST_NIBBLE       4'h0

// ----------------------------------------------------------------
// Clock source codes.
// ----------------------------------------------------------------
`define TMZ_CS_PIN           3'h0
`define TMZ_CS_PIN_INV       3'h1
`define TMZ_CS_INSTR         3'h2
`define TMZ_CS_HF_OSC        3'h3
`define TMZ_CS_LF_OSC        3'h4
`define TMZ_CS_MF_OSC        3'h5
`define TMZ_CS_SEC_OSC       3'h6
`define TMZ_CS_LOGIC_CELL    3'h7

// ----------------------------------------------------------------
// Timing: the instruction clock is the system clock divided by four.
// ----------------------------------------------------------------
`define TMZ_INSTR_DIV_LAST   2'h3

`endif

/* hw/tmz_timer.v */
// Functional notes
// RULE1: Runs as 8-bit period timer or 16-bit free-running timer per width bit.
// RULE2: Count advances once per prescaled rising edge of the selected clock.
// RULE3: 8-bit: low byte matches period buffer, clears, buffer reloads from high.
// RULE4: 16-bit: reading low byte copies counter high byte into high register.
// RULE5: 16-bit: high write only buffers; low write loads all 16 bits together.
// RULE6: 16-bit: counter wraps from all ones to zero and keeps counting.
// RULE7: Software must not reload the 16-bit count while running.
// RULE8: Three-bit source field picks pin, inverted pin, instruction clock, etc.
// RULE9: Synchronous mode aligns counts to instruction clock and stops in sleep.
// RULE10: Asynchronous mode counts every prescaled edge and keeps going in sleep.
// RULE11: Prescaler offers sixteen ratios from 1:1 up to 1:32768.
// RULE12: Prescale value n divides the input by two to the power n.
// RULE13: Hidden prescaler clears on low or control writes and on reset.
// RULE14: Postscaler divides events by field value plus one, 1:1 to 1:16.
// RULE15: Hidden postscaler clears on low or control writes and on reset.
// RULE16: Output toggles once per postscaled match or rollover event.
// RULE17: 8-bit mode with period zero holds the output high.
// RULE18: Output level readable in a status bit and driven to a port.
// RULE19: Interrupt flag sets on each output toggle; enable gates the interrupt.
// RULE20: Flag therefore sets every postscale value plus one events.
// RULE21: Asynchronous running with enabled interrupt wakes the device from sleep.
// RULE22: Enable bit turns timer on; it resets to zero.
// RULE23: Width bit set gives 16-bit mode, clear gives 8-bit mode.
// RULE24: While disabled, count and scalers hold and no flag is set.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tmz_consts.vh"

module tmz_timer (
	// Clock and reset.
	input  wire        clk,
	input  wire        reset_n,
	// APB slave.
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [15:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Clock sources, asynchronous to clk.
	input  wire        ext_clk_pin,
	input  wire        hf_osc_clk,
	input  wire        lf_osc_clk,
	input  wire        mf_osc_clk,
	input  wire        sec_osc_clk,
	input  wire        logic_cell_clk,
	// System state.
	input  wire        sleep_mode,
	// Timer outputs.
	output reg         timer_toggle_output,
	output reg         timer_irq,
	output reg         sleep_wake
);

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	reg  [7:0]  cnt_lo_ff;
	reg  [7:0]  cnt_hi_ff;
	reg  [7:0]  period_or_count_high_ff;
	reg  [7:0]  period_buf_ff;
	reg         module_enable_bit_ff;
	reg         wide_mode_select_ff;
	reg  [3:0]  postscale_field_ff;
	reg  [2:0]  clock_source_field_ff;
	reg         async_count_enable_ff;
	reg  [3:0]  prescale_field_ff;
	reg         timer_irq_flag_ff;
	reg         timer_irq_enable_ff;
	reg  [14:0] pre_cnt_ff;
	reg  [3:0]  post_cnt_ff;
	reg         pend_ff;
	reg  [1:0]  instr_div_ff;
	reg  [5:0]  sync1_ff;
	reg  [5:0]  sync2_ff;
	reg         sel_prev_ff;
	reg         nxt_sel_lvl;
	reg  [7:0]  nxt_cnt_lo;
	reg  [7:0]  nxt_cnt_hi;
	reg  [7:0]  nxt_period_buf;
	reg         nxt_evt;
	reg  [7:0]  nxt_rdata;
	reg         nxt_hit;

	wire [13:0] idx      = paddr[15:2];
	wire        acc      = psel & penable;
	wire        done     = acc & pready;
	wire        wr_done  = done & pwrite & ~pslverr;
	wire [7:0]  wbyte    = pwdata[7:0];
	wire        wr_lo    = wr_done & (idx == `TMZ_IDX_COUNT_LOW);
	wire        wr_hi    = wr_done & (idx == `TMZ_IDX_PERIOD_HIGH);
	wire        wr_c0    = wr_done & (idx == `TMZ_IDX_CTRL0);
	wire        wr_c1    = wr_done & (idx == `TMZ_IDX_CTRL1);
	wire        wr_irq   = wr_done & (idx == `TMZ_IDX_IRQ_CTRL);
	// Copied at the edge that captures the low byte, so both halves agree.
	wire        rd_lo    = acc & ~pready & ~pwrite & nxt_hit &
	                       (idx == `TMZ_IDX_COUNT_LOW);
	wire        en       = module_enable_bit_ff;
	// RULE13 RULE15 scaler clears
	wire        clr_scl  = wr_lo | wr_c0 | wr_c1;

	// ----------------------------------------------------------------
	// Clock source selection and edge detection.
	// ----------------------------------------------------------------
	wire [5:0]  src_raw  = {logic_cell_clk, sec_osc_clk, mf_osc_clk,
	                        lf_osc_clk, hf_osc_clk, ext_clk_pin};
	wire        instr_en = (instr_div_ff == `TMZ_INSTR_DIV_LAST);

	// Every pin and oscillator source is a level from another domain, so all six pass two flops.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_ff     <= 6'h00;
			sync2_ff     <= 6'h00;
			instr_div_ff <= 2'h0;
		end else begin
			sync1_ff     <= src_raw;
			sync2_ff     <= sync1_ff;
			instr_div_ff <= instr_div_ff + 2'h1;
		end
	end

	// RULE8 source select
	always @* begin
		case (clock_source_field_ff)
			`TMZ_CS_PIN:        nxt_sel_lvl = sync2_ff[0];
			`TMZ_CS_PIN_INV:    nxt_sel_lvl = ~sync2_ff[0];
			`TMZ_CS_HF_OSC:     nxt_sel_lvl = sync2_ff[1];
			`TMZ_CS_LF_OSC:     nxt_sel_lvl = sync2_ff[2];
			`TMZ_CS_MF_OSC:     nxt_sel_lvl = sync2_ff[3];
			`TMZ_CS_SEC_OSC:    nxt_sel_lvl = sync2_ff[4];
			`TMZ_CS_LOGIC_CELL: nxt_sel_lvl = sync2_ff[5];
			default:            nxt_sel_lvl = 1'b0;
		endcase
	end

	// A change of source may show one false edge, harmless while disabled.
	wire src_edge = (clock_source_field_ff == `TMZ_CS_INSTR) ? instr_en :
	                (nxt_sel_lvl & ~sel_prev_ff);

	// ----------------------------------------------------------------
	// Prescaler and synchronisation.
	// ----------------------------------------------------------------
	// RULE12 ratio mask
	wire [14:0] pre_mask = ~(15'h7fff << prescale_field_ff);
	// RULE11 prescaled tick
	wire        pre_tick = en & src_edge &
	                       ((pre_cnt_ff & pre_mask) == pre_mask);
	// RULE9 sync count gate
	wire        sync_go  = pend_ff & instr_en & ~sleep_mode;
	// RULE10 async count path
	wire        cnt_tick = async_count_enable_ff ? pre_tick : (en & sync_go);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_prev_ff <= 1'b0;
			pre_cnt_ff  <= 15'h0000;
			pend_ff     <= 1'b0;
		end else begin
			sel_prev_ff <= nxt_sel_lvl;
			// RULE13 prescaler clear
			if (clr_scl)
				pre_cnt_ff <= 15'h0000;
			else if (en && src_edge)
				pre_cnt_ff <= pre_cnt_ff + 15'h0001;
			// A pending tick waits for the instruction enable, never asleep.
			if (clr_scl || !en || async_count_enable_ff)
				pend_ff <= 1'b0;
			else if (pre_tick)
				pend_ff <= 1'b1;
			else if (sync_go)
				pend_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Counter.
	// ----------------------------------------------------------------
	wire [15:0] sum16 = {cnt_hi_ff, cnt_lo_ff} + 16'h0001;

	always @* begin
		nxt_cnt_lo     = cnt_lo_ff;
		nxt_cnt_hi     = cnt_hi_ff;
		nxt_period_buf = period_buf_ff;
		nxt_evt        = 1'b0;
		if (wr_lo) begin
			nxt_cnt_lo = wbyte;
			// RULE5 coherent load
			if (wide_mode_select_ff)
				nxt_cnt_hi = period_or_count_high_ff;
		end else if (cnt_tick) begin
			// RULE1 RULE23 width
			if (wide_mode_select_ff) begin
				// RULE2 RULE6 wrap
				nxt_cnt_lo = sum16[7:0];
				nxt_cnt_hi = sum16[15:8];
				nxt_evt    = (sum16 == 16'h0000);
			end else if (cnt_lo_ff == period_buf_ff) begin
				// RULE3 period match
				nxt_cnt_lo     = `TMZ_RST_BYTE;
				nxt_period_buf = period_or_count_high_ff;
				nxt_evt        = 1'b1;
			end else begin
				nxt_cnt_lo = cnt_lo_ff + 8'h01;
			end
		end
	end

	// RULE14 postscale divide
	wire post_evt = nxt_evt & ~clr_scl & (post_cnt_ff == postscale_field_ff);
	// RULE17 zero period
	// Gated by enable so the output bit keeps its zero reset value.
	wire out_hold = en & ~wide_mode_select_ff &
	                (period_or_count_high_ff == `TMZ_RST_BYTE);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_lo_ff           <= `TMZ_RST_BYTE;
			cnt_hi_ff           <= `TMZ_RST_BYTE;
			period_buf_ff       <= `TMZ_RST_BYTE;
			post_cnt_ff         <= `TMZ_RST_NIBBLE;
			timer_toggle_output <= 1'b0;
		end else begin
			cnt_lo_ff     <= nxt_cnt_lo;
			cnt_hi_ff     <= nxt_cnt_hi;
			period_buf_ff <= nxt_period_buf;
			// RULE15 postscaler clear
			if (clr_scl)
				post_cnt_ff <= `TMZ_RST_NIBBLE;
			else if (post_evt)
				post_cnt_ff <= `TMZ_RST_NIBBLE;
			else if (nxt_evt)
				post_cnt_ff <= post_cnt_ff + 4'h1;
			// RULE16 RULE18 output toggle
			if (out_hold)
				timer_toggle_output <= 1'b1;
			else if (post_evt)
				timer_toggle_output <= ~timer_toggle_output;
		end
	end

	// ----------------------------------------------------------------
	// Control, interrupt and wake.
	// ----------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			period_or_count_high_ff <= `TMZ_RST_BYTE;
			module_enable_bit_ff    <= 1'b0;
			wide_mode_select_ff     <= 1'b0;
			postscale_field_ff      <= `TMZ_RST_NIBBLE;
			clock_source_field_ff   <= `TMZ_RST_CS;
			async_count_enable_ff   <= 1'b0;
			prescale_field_ff       <= `TMZ_RST_NIBBLE;
			timer_irq_flag_ff       <= 1'b0;
			timer_irq_enable_ff     <= 1'b0;
			timer_irq               <= 1'b0;
			sleep_wake              <= 1'b0;
		end else begin
			if (wr_hi)
				period_or_count_high_ff <= wbyte;
			// RULE4 coherent read
			else if (rd_lo && wide_mode_select_ff)
				period_or_count_high_ff <= cnt_hi_ff;
			if (wr_c0) begin
				// RULE22 enable bit
				module_enable_bit_ff <= wbyte[`TMZ_CTRL0_EN_BIT];
				wide_mode_select_ff  <= wbyte[`TMZ_CTRL0_WIDE_BIT];
				postscale_field_ff   <=
					wbyte[`TMZ_CTRL0_POST_MSB:`TMZ_CTRL0_POST_LSB];
			end
			if (wr_c1) begin
				clock_source_field_ff <=
					wbyte[`TMZ_CTRL1_CS_MSB:`TMZ_CTRL1_CS_LSB];
				async_count_enable_ff <= wbyte[`TMZ_CTRL1_ASYNC_BIT];
				prescale_field_ff     <=
					wbyte[`TMZ_CTRL1_PRE_MSB:`TMZ_CTRL1_PRE_LSB];
			end
			if (wr_irq)
				timer_irq_enable_ff <= wbyte[`TMZ_IRQ_EN_BIT];
			// RULE19 RULE20 RULE24 flag set beats clear
			if (post_evt)
				timer_irq_flag_ff <= 1'b1;
			else if (wr_irq && wbyte[`TMZ_IRQ_FLAG_BIT])
				timer_irq_flag_ff <= 1'b0;
			timer_irq  <= timer_irq_flag_ff & timer_irq_enable_ff;
			// RULE21 sleep wake
			sleep_wake <= timer_irq_flag_ff & timer_irq_enable_ff &
			              sleep_mode & async_count_enable_ff & en;
		end
	end

	// ----------------------------------------------------------------
	// APB read mux and answer.
	// ----------------------------------------------------------------
	always @* begin
		nxt_hit   = 1'b1;
		nxt_rdata = `TMZ_RST_BYTE;
		if (paddr[1:0] != 2'h0) begin
			nxt_hit = 1'b0;
		end else begin
			case (idx)
				`TMZ_IDX_COUNT_LOW:   nxt_rdata = cnt_lo_ff;
				`TMZ_IDX_PERIOD_HIGH: nxt_rdata = period_or_count_high_ff;
				`TMZ_IDX_CTRL0:       nxt_rdata = {module_enable_bit_ff,
				                          1'b0, timer_toggle_output,
				                          wide_mode_select_ff,
				                          postscale_field_ff};
				`TMZ_IDX_CTRL1:       nxt_rdata = {clock_source_field_ff,
				                          async_count_enable_ff,
				                          prescale_field_ff};
				`TMZ_IDX_IRQ_CTRL:    nxt_rdata = {6'h00,
				                          timer_irq_enable_ff,
				                          timer_irq_flag_ff};
				default:              nxt_hit = 1'b0;
			endcase
		end
	end

	// One wait state keeps every answer coming straight from a flop.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= acc & ~pready;
			if (acc && !pready) begin
				prdata  <= (nxt_hit && !pwrite) ? {24'h00_0000, nxt_rdata}
				                               : 32'h0000_0000;
				pslverr <= ~nxt_hit;
			end else begin
				// Dropped with the answer so an error never outlives ready.
				pslverr <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

/* bench/tmz_timer_chk.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Port-level checks of the bus answer and the wake output.
// ----------------------------------------------------------------
module tmz_timer_chk (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        reset_n,
	// Bus.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// System state and outputs.
	input wire logic        sleep_mode,
	input wire logic        timer_irq,
	input wire logic        sleep_wake
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	a_ready_second: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_access: assert property (pready |-> s_access)
		else $error("ready outside access phase");
	a_idle_quiet: assert property (!psel ##1 !psel |-> !pready)
		else $error("ready while idle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 0)
		else $error("refused read returned data");
	a_wake_irq: assert property (sleep_wake |-> timer_irq)
		else $error("wake without interrupt");
	a_wake_sleep: assert property (sleep_wake |-> $past(sleep_mode))
		else $error("wake while awake");
endmodule

`default_nettype wire

/* bench/tmz_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmz_consts.vh"

module tmz_timer_bench;
	localparam logic [15:0] adr_lo  = {`TMZ_IDX_COUNT_LOW, 2'b00};
	localparam logic [15:0] adr_hi  = {`TMZ_IDX_PERIOD_HIGH, 2'b00};
	localparam logic [15:0] adr_c0  = {`TMZ_IDX_CTRL0, 2'b00};
	localparam logic [15:0] adr_c1  = {`TMZ_IDX_CTRL1, 2'b00};
	localparam logic [15:0] adr_irq = {`TMZ_IDX_IRQ_CTRL, 2'b00};
	logic        clk = 0;
	logic        reset_n = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [5:0]  src = 6'h00;
	logic        sleep_mode = 0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         timer_toggle_output;
	wire         timer_irq;
	wire         sleep_wake;
	logic [31:0] rd;
	logic        er;
	int          errors = 0;
	int          checked = 0;
	int          srcs [6] = '{0, 3, 4, 5, 6, 7};

	always #5 clk = ~clk;

	tmz_timer dut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_clk_pin(src[0]), .hf_osc_clk(src[1]), .lf_osc_clk(src[2]),
		.mf_osc_clk(src[3]), .sec_osc_clk(src[4]), .logic_cell_clk(src[5]),
		.sleep_mode(sleep_mode), .timer_toggle_output(timer_toggle_output),
		.timer_irq(timer_irq), .sleep_wake(sleep_wake));

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task print_verdict;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($urandom), d};
		@(posedge clk);
		penable <= 1;
		// Only the watchdog ends a wait for ready.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Edges are eight cycles apart, slower than the instruction clock.
	task pulse(input int s, input int k);
		repeat (k) begin
			src[s] <= 1;
			repeat (4) @(posedge clk);
			src[s] <= 0;
			repeat (4) @(posedge clk);
		end
		repeat (12) @(posedge clk);
	endtask

	task do_reset;
		reset_n <= 0;
		repeat (8) @(posedge clk);
		reset_n <= 1;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		print_verdict;
	end

	// ----------------------------------------------------------------
	// Main sequence against an integer model.
	// ----------------------------------------------------------------
	initial begin
		int r, cs, ps, wd, asy, slp, hi, lo0, pre, post, k;
		int tk, low, bv, cnt, ev, tg, out, flg;
		void'($urandom(32'h0383_1d81));
		do_reset;
		for (int a = 0; a < 5; a++) begin
			bus(0, adr_lo + 16'(4 * a), 0);
			check(rd, 0);
		end
		bus(0, adr_irq + 16'h0004, 0);
		check(er, 1);
		bus(1, adr_lo + 16'h0001, 8'h55);
		check(er, 1);
		bus(0, adr_lo, 0);
		check(rd, 0);
		for (r = 0; r < 9; r++) begin
			cs = (r == 6) ? 2 : (r == 8) ? 1 : srcs[r % 6];
			ps = (r == 8) ? 0 : r % 6;
			wd = r % 2;
			asy = r < 6;
			slp = (r == 6) ? 1 : (r == 7) ? 0 : $urandom % 2;
			hi = wd ? 255 : (r == 2 ? 0 : 1 + $urandom % 7);
			lo0 = wd ? 248 + $urandom % 8 : 0;
			pre = $urandom % 3;
			post = $urandom % 3;
			k = 8 + $urandom % 24;
			do_reset;
			sleep_mode <= slp[0];
			bus(1, adr_c1, 8'(cs * 32 + asy * 16 + pre));
			bus(1, adr_c0, 8'(wd * 16 + post));
			bus(1, adr_irq, 8'h02);
			bus(1, adr_hi, 8'(hi));
			// no running reload
			// The wide count is loaded before enabling, never while running.
			if (wd) bus(1, adr_lo, 8'(lo0));
			bus(1, adr_c0, 8'(128 + wd * 16 + post));
			pulse(ps, k);
			tk = (!asy && slp) ? 0 : k >> pre;
			low = lo0;
			bv = 0;
			cnt = hi * 256 + lo0;
			ev = 0;
			repeat (tk) begin
				if (wd) begin
					cnt = (cnt + 1) % 65536;
					if (cnt == 0) ev++;
				end else if (low == bv) begin
					low = 0;
					bv = hi;
					ev++;
				end else begin
					low++;
				end
			end
			if (wd) low = cnt % 256;
			tg = ev / (post + 1);
			out = (!wd && hi == 0) ? 1 : tg % 2;
			flg = tg > 0;
			bus(0, adr_lo, 0);
			check(rd, low);
			bus(0, adr_hi, 0);
			check(rd, wd ? cnt / 256 : hi);
			bus(0, adr_c0, 0);
			check(rd, 128 + out * 32 + wd * 16 + post);
			bus(0, adr_irq, 0);
			check(rd, 2 + flg);
			check(timer_toggle_output, out);
			check(timer_irq, flg);
			check(sleep_wake, flg & slp & asy);
			bus(1, adr_irq, 8'h03);
			bus(1, adr_c0, 8'(wd * 16 + post));
			pulse(ps, 4);
			bus(0, adr_lo, 0);
			check(rd, low);
			bus(0, adr_irq, 0);
			check(rd, 2);
		end
		print_verdict;
	end
endmodule

bind tmz_timer tmz_timer_chk u_chk (.clk(clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
	.timer_irq(timer_irq), .sleep_wake(sleep_wake));

`default_nettype wire
